// file: core/msd_pkg.sv
// Purpose: Constants and carriers for the memory space decoder
// Assumes: 16-bit CPU address, 64 KB space
// Notes:   Shared by the decoder and its range comparator
package msd_pkg;

	// ==========================================================
	// Fixed regions
	localparam logic [15:0] MSD_VEC_LO      = 16'h0000;
	localparam logic [15:0] MSD_VEC_HI      = 16'h003f;
	localparam logic [15:0] MSD_TCALL_LO    = 16'h0040;
	localparam logic [15:0] MSD_TCALL_HI    = 16'h007f;
	localparam logic [15:0] MSD_OPT0_LO     = 16'h0080;
	localparam logic [15:0] MSD_OPT0_HI     = 16'h0084;
	localparam logic [15:0] MSD_OPT1_LO     = 16'h1080;
	localparam logic [15:0] MSD_OPT1_HI     = 16'h1084;
	localparam logic [15:0] MSD_DBG0_LO     = 16'h0085;
	localparam logic [15:0] MSD_DBG0_HI     = 16'h008e;
	localparam logic [15:0] MSD_DBG1_LO     = 16'h1085;
	localparam logic [15:0] MSD_DBG1_HI     = 16'h108e;
	localparam logic [15:0] MSD_FCALL_LO    = 16'h0800;
	localparam logic [15:0] MSD_FCALL_HI    = 16'h0fff;
	localparam logic [15:0] MSD_BOOT0_HI    = 16'h0fff;
	localparam logic [15:0] MSD_GPR_LO      = 16'hfee0;
	localparam logic [15:0] MSD_GPR_HI      = 16'hfeff;
	localparam logic [15:0] MSD_SPF_LO      = 16'hff00;
	localparam logic [15:0] MSD_SPF_HI      = 16'hffff;
	localparam logic [15:0] MSD_HRAM_HI     = 16'hfedf;

	// ==========================================================
	// Reset values of size selects, and the 48 KB memory size select
	localparam logic [7:0]  MSD_MSS_RST     = 8'hcf;
	localparam logic [7:0]  MSD_XSS_RST     = 8'h0c;
	localparam logic [7:0]  MSD_MSS_48K     = 8'hcc;

	// ==========================================================
	// Size select fields and the block number shift
	localparam int          MSD_ROM_LSB     = 0;
	localparam int          MSD_HRAM_LSB    = 5;
	localparam int          MSD_XRAM_LSB    = 0;
	localparam int          MSD_BLK_SHIFT   = 10;

	typedef enum logic [3:0] {
		MSD_R_NONE,
		MSD_R_VEC,
		MSD_R_TCALL,
		MSD_R_OPT,
		MSD_R_DBG,
		MSD_R_FCALL,
		MSD_R_ROM,
		MSD_R_XRAM,
		MSD_R_HRAM,
		MSD_R_GPR,
		MSD_R_SPF
	} msd_region_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
	} msd_req_t;

	typedef struct packed {
		logic        valid;
		msd_region_t region;
		logic [5:0]  block;
		logic        wr_blocked;
	} msd_rsp_t;

endpackage

// file: core/msd_range.sv
// Purpose: Inclusive address range compare
// Assumes: Bounds may be dynamic
// Notes:   Used once per address range; option and debug areas take two each
`timescale 1ns/1ps
module msd_range import msd_pkg::*; (
	input  wire logic [15:0] addr,
	input  wire logic [15:0] lo,
	input  wire logic [15:0] hi,
	output logic             hit
);
	assign hit = (addr >= lo) && (addr <= hi);
endmodule // msd_range

// file: core/msd_decoder.sv
// Purpose: Decode CPU accesses into memory regions of a 64 KB space
// Assumes: One access request per cycle, answer one cycle later
// Notes:   Size selects are plain ports, not bus registers
`timescale 1ns/1ps
module msd_decoder import msd_pkg::*; #(
	parameter int ROM_KB   = 24,
	parameter int HRAM_B   = 1024,
	parameter bit HAS_DBG  = 1'b0
) (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire msd_req_t    REQ,
	input  wire logic        MSS_WE,
	input  wire logic [7:0]  MSS_WDATA,
	input  wire logic        XSS_WE,
	input  wire logic [7:0]  XSS_WDATA,
	input  wire logic        BOOT_SWAP,
	input  wire logic        BOOT0_PROTECT,
	output msd_rsp_t         RSP,
	output logic [7:0]       MEMORY_SIZE_SELECT,
	output logic [7:0]       EXPANSION_RAM_SIZE_SELECT
);

	// Sizes the decode tables cannot serve
	if (HRAM_B < 1 || HRAM_B > 1024 || ROM_KB < 1 || ROM_KB > 128) begin : g_bad
		$error("msd_decoder: unsupported size parameters");
	end

	// ==========================================================
	// Size select registers
	logic [7:0]  mss_q;
	logic [7:0]  xss_q;

	always_ff @(posedge CLK) begin
		if (SYS_RST)
			mss_q <= MSD_MSS_RST;
		else if (MSS_WE)
			mss_q <= MSS_WDATA;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST)
			xss_q <= MSD_XSS_RST;
		else if (XSS_WE)
			xss_q <= XSS_WDATA;
	end

	assign MEMORY_SIZE_SELECT        = mss_q;
	assign EXPANSION_RAM_SIZE_SELECT = xss_q;

	// ==========================================================
	// Region bounds from size selects
	// ROM code F maps 60 KB directly, up to EFFFH
	logic [15:0] rom_hi;
	logic [15:0] hram_lo;
	logic [15:0] xram_lo;
	logic [15:0] xram_hi;
	logic        xram_en;

	always_comb begin
		// Low ROM code maps from 0000H
		case (mss_q[3:0])
			4'h4:    rom_hi = 16'h3fff;
			4'h6:    rom_hi = 16'h5fff;
			4'h8:    rom_hi = 16'h7fff;
			4'hc:    rom_hi = 16'hbfff;
			4'hf:    rom_hi = 16'hefff;
			default: rom_hi = 16'h5fff;
		endcase
		// High-speed RAM sits below general registers
		case (mss_q[7:5])
			3'h0:    hram_lo = 16'hfbe0;
			default: hram_lo = 16'hfae0;
		endcase
		// Expansion RAM placed from F800H downward by size
		case (xss_q[3:0])
			4'h0:    xram_lo = 16'he000;
			4'h4:    xram_lo = 16'he800;
			4'hb:    xram_lo = 16'hf000;
			4'ha:    xram_lo = 16'hf400;
			default: xram_lo = 16'hf800;
		endcase
		xram_hi = 16'hf7ff;
		xram_en = (xss_q[3:0] != 4'hc);
	end

	// ==========================================================
	// Region hits
	logic [15:0] a;
	logic        h_vec, h_tc, h_o0, h_o1, h_d0, h_d1, h_fc;
	logic        h_rom, h_xr, h_hr, h_gpr, h_spf;

	assign a = REQ.addr;

	msd_range u_vec (.addr(a), .lo(MSD_VEC_LO), .hi(MSD_VEC_HI),
		.hit(h_vec));
	msd_range u_tc (.addr(a), .lo(MSD_TCALL_LO), .hi(MSD_TCALL_HI),
		.hit(h_tc));
	msd_range u_o0 (.addr(a), .lo(MSD_OPT0_LO), .hi(MSD_OPT0_HI),
		.hit(h_o0));
	msd_range u_o1 (.addr(a), .lo(MSD_OPT1_LO), .hi(MSD_OPT1_HI),
		.hit(h_o1));
	msd_range u_d0 (.addr(a), .lo(MSD_DBG0_LO), .hi(MSD_DBG0_HI),
		.hit(h_d0));
	msd_range u_d1 (.addr(a), .lo(MSD_DBG1_LO), .hi(MSD_DBG1_HI),
		.hit(h_d1));
	msd_range u_fc (.addr(a), .lo(MSD_FCALL_LO), .hi(MSD_FCALL_HI),
		.hit(h_fc));
	msd_range u_rom (.addr(a), .lo(MSD_VEC_LO), .hi(rom_hi),
		.hit(h_rom));
	msd_range u_xr (.addr(a), .lo(xram_lo), .hi(xram_hi),
		.hit(h_xr));
	msd_range u_hr (.addr(a), .lo(hram_lo), .hi(MSD_HRAM_HI),
		.hit(h_hr));
	msd_range u_gpr (.addr(a), .lo(MSD_GPR_LO), .hi(MSD_GPR_HI),
		.hit(h_gpr));
	msd_range u_spf (.addr(a), .lo(MSD_SPF_LO), .hi(MSD_SPF_HI),
		.hit(h_spf));

	// ==========================================================
	// Region priority
	msd_region_t region_d;
	logic        dbg_on;
	logic        opt1_on;

	assign opt1_on = BOOT_SWAP;
	assign dbg_on  = HAS_DBG && BOOT_SWAP;

	always_comb begin
		// Fixed small areas win over the ROM span
		if (h_spf)
			region_d = MSD_R_SPF;
		else if (h_gpr)
			region_d = MSD_R_GPR;
		else if (h_hr)
			region_d = MSD_R_HRAM;
		else if (xram_en && h_xr)
			region_d = MSD_R_XRAM;
		else if (h_vec)
			region_d = MSD_R_VEC;
		else if (h_tc)
			region_d = MSD_R_TCALL;
		else if (h_o0 || (opt1_on && h_o1))
			region_d = MSD_R_OPT;
		else if (dbg_on && (h_d0 || h_d1))
			region_d = MSD_R_DBG;
		else if (h_fc)
			region_d = MSD_R_FCALL;
		else if (h_rom)
			region_d = MSD_R_ROM;
		else
			region_d = MSD_R_NONE;
	end

	// ==========================================================
	// Answer register
	logic        flash_d;
	logic        boot0_d;
	msd_rsp_t    rsp_q;

	assign flash_d = (region_d == MSD_R_VEC) || (region_d == MSD_R_TCALL)
		|| (region_d == MSD_R_OPT) || (region_d == MSD_R_DBG)
		|| (region_d == MSD_R_FCALL) || (region_d == MSD_R_ROM);
	assign boot0_d = flash_d && (a <= MSD_BOOT0_HI);

	// Bounds sampled at request time only
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid  <= REQ.valid;
			rsp_q.region <= region_d;
			// Block number from 1 KB pages
			rsp_q.block  <= a[15:MSD_BLK_SHIFT];
			rsp_q.wr_blocked <= REQ.valid && REQ.write && boot0_d
				&& BOOT0_PROTECT;
		end
	end

	assign RSP = rsp_q;

	// ==========================================================
	// Checks
	// Reset value
	property p_rst_val;
		@(posedge CLK) $past(SYS_RST) |-> (mss_q == MSD_MSS_RST)
			&& (xss_q == MSD_XSS_RST);
	endproperty
	a_rst_val: assert property (p_rst_val)
		else $error("size selects wrong after reset");

	property p_spf;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && a[15:8] == 8'hff) |=> (RSP.region == MSD_R_SPF);
	endproperty
	a_spf: assert property (p_spf)
		else $error("special area not decoded");

	property p_gpr;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && a >= 16'hfee0 && a <= 16'hfeff)
			|=> (RSP.region == MSD_R_GPR);
	endproperty
	a_gpr: assert property (p_gpr)
		else $error("register area not decoded");

	property p_vec;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && a < 16'h0040) |=> (RSP.region == MSD_R_VEC);
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector area not decoded");

	property p_tc;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && a[15:6] == 10'h001) |=> (RSP.region == MSD_R_TCALL);
	endproperty
	a_tc: assert property (p_tc)
		else $error("table call area not decoded");

	property p_opt;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && a >= 16'h0080 && a <= 16'h0084)
			|=> (RSP.region == MSD_R_OPT);
	endproperty
	a_opt: assert property (p_opt)
		else $error("option bytes not decoded");

	property p_opt1;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && BOOT_SWAP && a >= 16'h1080 && a <= 16'h1084)
			|=> (RSP.region == MSD_R_OPT);
	endproperty
	a_opt1: assert property (p_opt1)
		else $error("swap option bytes not decoded");

	property p_fc;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && a[15:11] == 5'h01) |=> (RSP.region == MSD_R_FCALL);
	endproperty
	a_fc: assert property (p_fc)
		else $error("fixed call area not decoded");

	property p_blk;
		@(posedge CLK) disable iff (SYS_RST)
		REQ.valid |=> (RSP.block == $past(a[15:10]));
	endproperty
	a_blk: assert property (p_blk)
		else $error("block number wrong");

	property p_wp;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && REQ.write && BOOT0_PROTECT && a <= 16'h0fff)
			|=> RSP.wr_blocked;
	endproperty
	a_wp: assert property (p_wp)
		else $error("boot cluster write not blocked");

	// Flag only a protected boot write, never reads
	property p_wp_only;
		@(posedge CLK) disable iff (SYS_RST)
		!(REQ.valid && REQ.write && BOOT0_PROTECT && a <= 16'h0fff)
			|=> !RSP.wr_blocked;
	endproperty
	a_wp_only: assert property (p_wp_only)
		else $error("write flagged without protection");

	property p_dbg;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && HAS_DBG && BOOT_SWAP
			&& (a[15:8] == 8'h00 || a[15:8] == 8'h10)
			&& a[7:0] >= 8'h85 && a[7:0] <= 8'h8e)
			|=> (RSP.region == MSD_R_DBG);
	endproperty
	a_dbg: assert property (p_dbg)
		else $error("debug identifiers not decoded");

	property p_hram;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && mss_q[7:5] != 3'h0 && a >= 16'hfae0
			&& a <= 16'hfedf) |=> (RSP.region == MSD_R_HRAM);
	endproperty
	a_hram: assert property (p_hram)
		else $error("high-speed RAM not decoded");

	property p_rom;
		@(posedge CLK) disable iff (SYS_RST)
		(REQ.valid && mss_q[3:0] == 4'h6 && a >= 16'h1100
			&& a <= 16'h5fff) |=> (RSP.region == MSD_R_ROM);
	endproperty
	a_rom: assert property (p_rom)
		else $error("24 KB ROM span not decoded");

	property p_sel_wr;
		@(posedge CLK) disable iff (SYS_RST)
		(MSS_WE || XSS_WE) |=>
			(!$past(MSS_WE) || (mss_q == $past(MSS_WDATA)))
			&& (!$past(XSS_WE) || (xss_q == $past(XSS_WDATA)));
	endproperty
	a_sel_wr: assert property (p_sel_wr)
		else $error("size select not taken");

endmodule // msd_decoder

// file: tb/msd_cpu_model.sv
// Purpose: CPU side of decoder requests
// Assumes: Bench sets commands at rising edge
// Notes:   Idle address is not held
`timescale 1ns/1ps
module msd_cpu_model import msd_pkg::*; (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        CMD_V,
	input  wire logic        CMD_W,
	input  wire logic [15:0] CMD_A,
	output msd_req_t         REQ
);
	logic [15:0] last_q;
	// ==========================================================
	// Request drive
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			last_q <= 16'h0000;
		end else if (CMD_V) begin
			last_q <= CMD_A;
		end
	end
	// one 16-bit address
	// Inverted stale address, never a lucky match
	always_comb begin
		REQ.valid = CMD_V;
		REQ.write = CMD_V & CMD_W;
		REQ.addr  = CMD_V ? CMD_A : ~last_q;
	end
endmodule // msd_cpu_model

// file: tb/tb_top.sv
// Purpose: Self-checking bench of the decoder
// Assumes: Debug variant, response one cycle on
// Notes:   Random traffic plus corner addresses
`timescale 1ns/1ps
module tb_top import msd_pkg::*;;
	logic        clk, rst, cv, cw, mwe, xwe, sw, pr;
	logic [15:0] ca;
	logic [7:0]  mwd, xwd, mso, xso, m_mss, m_xss, pmd, pxd;
	msd_req_t    req;
	msd_rsp_t    rsp;
	int          n_errors, tests_run, c, s, i;
	logic        pv, pw, pmw, pxw, sw_n, pr_n;
	msd_region_t pr_e;
	logic [5:0]  pb;
	logic [7:0]  cfg_m [7] = '{8'h04, 8'hc6, 8'hc8, 8'hcc, 8'hcf,
		8'hcc, 8'hcc};
	logic [7:0]  cfg_x [7] = '{8'h0c, 8'h0c, 8'h0c, 8'h0a, 8'h0b,
		8'h04, 8'h00};
	logic [15:0] cor [30] = '{16'h0000, 16'h003f, 16'h0040, 16'h007f,
		16'h0080, 16'h0084, 16'h0085, 16'h008e, 16'h008f, 16'h0800,
		16'h0fff, 16'h1080, 16'h1084, 16'h1085, 16'h108e, 16'h108f,
		16'h3fff, 16'h5fff, 16'hbfff, 16'he000, 16'he800, 16'hf400,
		16'hf7ff, 16'hfae0, 16'hfbe0, 16'hfedf, 16'hfee0, 16'hfeff,
		16'hff00, 16'hffff};
	always #5 clk = ~clk;
	msd_cpu_model cpu_u (.CLK(clk), .SYS_RST(rst), .CMD_V(cv),
		.CMD_W(cw), .CMD_A(ca), .REQ(req));
	msd_decoder #(.HAS_DBG(1'b1)) dut_u (.CLK(clk), .SYS_RST(rst),
		.REQ(req), .MSS_WE(mwe), .MSS_WDATA(mwd), .XSS_WE(xwe),
		.XSS_WDATA(xwd), .BOOT_SWAP(sw), .BOOT0_PROTECT(pr), .RSP(rsp),
		.MEMORY_SIZE_SELECT(mso), .EXPANSION_RAM_SIZE_SELECT(xso));
	// ==========================================================
	// Expected region
	function automatic msd_region_t ex(logic [15:0] a, logic [7:0] m,
		logic [7:0] x, logic w);
		logic [15:0] rt, hl, xl;
		logic        xe;
		case (m[3:0])
			4'h4: rt = 16'h3fff;
			4'h8: rt = 16'h7fff;
			4'hc: rt = 16'hbfff;
			4'hf: rt = 16'hefff;
			default: rt = 16'h5fff;
		endcase
		hl = (m[7:5] == 3'h0) ? 16'hfbe0 : 16'hfae0;
		xe = 1'b1;
		case (x[3:0])
			4'h0: xl = 16'he000;
			4'h4: xl = 16'he800;
			4'hb: xl = 16'hf000;
			4'ha: xl = 16'hf400;
			default: xe = 1'b0;
		endcase
		if (a >= 16'hff00) return MSD_R_SPF;
		if (a >= 16'hfee0) return MSD_R_GPR;
		if (a >= hl) return MSD_R_HRAM;
		if (xe && a >= xl && a <= 16'hf7ff) return MSD_R_XRAM;
		if (a <= 16'h003f) return MSD_R_VEC;
		if (a <= 16'h007f) return MSD_R_TCALL;
		if (a <= 16'h0084) return MSD_R_OPT;
		if (w && a >= 16'h1080 && a <= 16'h1084) return MSD_R_OPT;
		if (w && (a[15:8] == 8'h00 || a[15:8] == 8'h10)
			&& a[7:0] >= 8'h85 && a[7:0] <= 8'h8e) return MSD_R_DBG;
		if (a >= 16'h0800 && a <= 16'h0fff) return MSD_R_FCALL;
		if (a <= rt) return MSD_R_ROM;
		return MSD_R_NONE;
	endfunction
	// ==========================================================
	// Check and report
	task automatic chk(input logic [15:0] seen, input logic [15:0] e);
		tests_run++;
		if (seen !== e) begin
			n_errors++;
			$display("wrong value at %0t: saw %h not %h", $time, seen, e);
		end
	endtask
	task automatic summarize();
		$display("errors %0d in %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// One request per edge, answer checked an edge later
	task automatic step(input logic v, input logic w,
		input logic [15:0] a, input logic m, input logic [7:0] md,
		input logic x, input logic [7:0] xd);
		@(posedge clk);
		cv <= v;
		cw <= w;
		ca <= a;
		mwe <= m;
		mwd <= md;
		xwe <= x;
		xwd <= xd;
		sw <= sw_n;
		pr <= pr_n;
		#1;
		chk(rsp.valid, pv);
		if (pv) begin
			chk(rsp.region, pr_e);
			chk(rsp.block, pb);
			chk(rsp.wr_blocked, pw);
		end
		if (pmw) m_mss = pmd;
		if (pxw) m_xss = pxd;
		chk(mso, m_mss);
		chk(xso, m_xss);
		pv = v;
		pr_e = ex(a, m_mss, m_xss, sw_n);
		pb = a[15:10];
		pw = w & pr_n & (a <= 16'h0fff);
		pmw = m;
		pmd = md;
		pxw = x;
		pxd = xd;
	endtask
	task automatic do_rst();
		@(posedge clk);
		rst <= 1'b1;
		cv <= 1'b0;
		mwe <= 1'b0;
		xwe <= 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		{pv, pmw, pxw} = 3'h0;
		m_mss = 8'hcf;
		m_xss = 8'h0c;
	endtask
	// ==========================================================
	// Sequence
	initial begin
		{clk, rst, cv, cw, mwe, xwe, sw, pr, sw_n, pr_n} = 10'h000;
		{ca, mwd, xwd} = 32'h00000000;
		n_errors = 0;
		tests_run = 0;
		void'($urandom(59270));
		do_rst();
		for (c = 0; c < 7; c++) begin
			for (s = 0; s < 2; s++) begin
				sw_n = s[0];
				step(1'b1, 1'b0, 16'h5000, 1'b1, cfg_m[c], 1'b0, 8'h00);
				step(1'b1, 1'b1, 16'h8000, 1'b0, 8'h00, 1'b1, cfg_x[c]);
				for (i = 0; i < 30; i++) begin
					pr_n = i[0];
					step(1'b1, i[1], cor[i], 1'b0, 8'h00, 1'b0, 8'h00);
				end
			end
		end
		repeat (400) begin
			sw_n = 1'($urandom);
			pr_n = 1'($urandom);
			step(1'($urandom), 1'($urandom), 16'($urandom), 1'b0, 8'h00,
				1'b0, 8'h00);
		end
		do_rst();
		step(1'b1, 1'b1, 16'h0400, 1'b0, 8'h00, 1'b0, 8'h00);
		step(1'b0, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0, 8'h00);
		summarize();
	end
	initial begin
		#200000;
		n_errors++;
		summarize();
	end
endmodule // tb_top
